// ### rtl/elfs_defines.vh
// Purpose: Constants for the ECG lead formation and select block
// Assumes: Included by bare name; definitions only
// Notes:   Mode code is {frame_data_format, input_topology_sel, common_electrode_enable}
// How it works
// - With the input topology bit at 1 the channels arrive as analog leads against the averaged terminal.
// - In analog lead mode the second lead arrives inverted and is negated back in the datapath.
// - Digital lead mode forms LA-RA, LL-RA and LL-LA from electrode samples.
// - Common electrode A mode gives word 3 as chest minus the sum of the two limb leads over three.
// - Digital lead mode ignores the common-mode reference selection.
// - Digital lead mode is offered only at 2 kHz and 16 kHz; other rates raise mode_unsupported.
// - Single-ended electrode mode outputs LA, LL and RA against the selected common-mode level.
// - Common electrode B mode outputs LA, LL and the chest electrode against the common electrode.
// - The frame data format bit picks lead output at 0 and electrode output at 1.
// - The input topology bit picks single-ended inputs at 0 and differential inputs at 1.
// - The common-electrode enable bit, with the other two, picks one of the five modes.
// - At 128 kHz only analog lead mode gives lead output; the code sets mode_unsupported only for digital lead mode there, not CE A.
// - The internal reference level is subtracted from every channel sample before the mode arithmetic.
`ifndef ELFS_DEFINES_VH
`define ELFS_DEFINES_VH
`define ELFS_MODE_ANALOG_LEAD 3'h2
`define ELFS_MODE_DIGITAL_LEAD 3'h0
`define ELFS_MODE_CE_A 3'h1
`define ELFS_MODE_SE_ELECTRODE 3'h4
`define ELFS_MODE_CE_B 3'h5
`define ELFS_RATE_2K 2'h0
`define ELFS_RATE_16K 2'h1
`define ELFS_RATE_128K 2'h2
`define ELFS_DATA_W 24
`define ELFS_FIFO_DEPTH 8
`endif

// ### rtl/elfs_fifo.v
// Purpose: Small synchronous FIFO for output frames
// Assumes: One clock, active-low synchronous-domain reset copy
// Notes:   Read data come from a register; full and empty are exact
`timescale 1ns/1ns
`default_nettype none
module elfs_fifo #(
  parameter WIDTH = 72,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output reg  [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_reg;
  reg [AW-1:0]    rd_ptr_reg;
  reg [AW:0]      count_reg;
  reg             out_valid_reg;
  wire            push;
  wire            pop_mem;
  // Output register refills when empty or being drained
  assign pop_mem   = (count_reg != {(AW+1){1'b0}}) && (!out_valid_reg || out_ready);
  assign in_ready  = (count_reg != DEPTH[AW:0]);
  assign push      = in_valid && in_ready;
  assign out_valid = out_valid_reg;
  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
    if (pop_mem) begin
      out_data <= mem[rd_ptr_reg];
    end
  end
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg    <= {AW{1'b0}};
      rd_ptr_reg    <= {AW{1'b0}};
      count_reg     <= {(AW+1){1'b0}};
      out_valid_reg <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_reg + 1'b1;
      end
      if (pop_mem) begin
        rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;
      end
      if (push && !pop_mem) begin
        count_reg <= count_reg + 1'b1;
      end else if (!push && pop_mem) begin
        count_reg <= count_reg - 1'b1;
      end
      if (pop_mem) begin
        out_valid_reg <= 1'b1;
      end else if (out_ready) begin
        out_valid_reg <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ### rtl/elfs_lead_select.v
// Purpose: Forms the three frame data words from the ECG channel samples per mode
// Assumes: Samples are signed, synchronous to clk_sys, one set per sample_valid
// Notes:   One-stage pipeline into a FIFO of 8 entries plus its output register; back-pressure via sample_ready
`timescale 1ns/1ns
`default_nettype none
`include "elfs_defines.vh"
module elfs_lead_select #(
  parameter DW    = `ELFS_DATA_W,
  parameter DEPTH = `ELFS_FIFO_DEPTH
) (
  input  wire          clk_sys,
  input  wire          arst_n,
  input  wire          frame_data_format,
  input  wire          input_topology_sel,
  input  wire          common_electrode_enable,
  input  wire [1:0]    data_rate_sel,
  input  wire [5:0]    common_mode_ref_sel,
  input  wire [DW-1:0] internal_cm_reference,
  input  wire          sample_valid,
  output wire          sample_ready,
  input  wire [DW-1:0] ch1_sample,
  input  wire [DW-1:0] ch2_sample,
  input  wire [DW-1:0] ch3_sample,
  output reg  [5:0]    cm_select_applied,
  output reg           mode_unsupported,
  output wire          frame_valid,
  input  wire          frame_ready,
  output wire [DW-1:0] word1,
  output wire [DW-1:0] word2,
  output wire [DW-1:0] word3
);
  reg              rst_meta_reg;
  reg              rst_sync_reg;
  wire             rst_n;
  wire [2:0]       mode;
  reg              stage_valid_reg;
  reg  [DW-1:0]    w1_reg;
  reg  [DW-1:0]    w2_reg;
  reg  [DW-1:0]    w3_reg;
  reg  [DW-1:0]    w1_next;
  reg  [DW-1:0]    w2_next;
  reg  [DW-1:0]    w3_next;
  reg              bad_next;
  wire [DW-1:0]    s1;
  wire [DW-1:0]    s2;
  wire [DW-1:0]    s3;
  wire             fifo_in_ready;
  wire [3*DW-1:0]  fifo_out;
  wire             advance;
  localparam       AW = $clog2(DEPTH);
  wire             digital_lead;
  wire             rate_ok;
  wire [DW-1:0]    lead_i;
  wire [DW-1:0]    lead_ii;
  wire [DW-1:0]    lead_iii;
  wire [DW-1:0]    lead_ii_fixed;
  wire [DW-1:0]    limb_sum;
  wire [DW-1:0]    ct_third;
  wire [DW-1:0]    chest_vs_ct;

  // Zero-reference a sample against the internal reference level
  function [DW-1:0] zref;
    input [DW-1:0] x;
    input [DW-1:0] r;
    begin
      zref = x - r;
    end
  endfunction

  // Signed divide by three, used for the central terminal correction
  function [DW-1:0] div3;
    input [DW-1:0] x;
    begin
      div3 = $signed(x) / $signed({{(DW-2){1'b0}}, 2'b11});
    end
  endfunction

  // True for the one mode that computes leads in the core
  function is_digital_lead;
    input [2:0] m;
    begin
      is_digital_lead = (m == `ELFS_MODE_DIGITAL_LEAD);
    end
  endfunction

  // Lead arithmetic exists only at the two slower output rates
  function rate_allows_digital;
    input [1:0] rate;
    begin
      rate_allows_digital = (rate == `ELFS_RATE_2K) || (rate == `ELFS_RATE_16K);
    end
  endfunction

  // True for the five codes that name a real input arrangement
  function mode_defined;
    input [2:0] m;
    begin
      case (m)
        `ELFS_MODE_ANALOG_LEAD:  mode_defined = 1'b1;
        `ELFS_MODE_DIGITAL_LEAD: mode_defined = 1'b1;
        `ELFS_MODE_CE_A:         mode_defined = 1'b1;
        `ELFS_MODE_SE_ELECTRODE: mode_defined = 1'b1;
        `ELFS_MODE_CE_B:         mode_defined = 1'b1;
        default:                 mode_defined = 1'b0;
      endcase
    end
  endfunction

  // Reset enters at once and leaves two edges after the pin rises
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  assign rst_n = rst_sync_reg;

  assign mode = {frame_data_format, input_topology_sel, common_electrode_enable};
  assign advance      = !stage_valid_reg || fifo_in_ready;
  assign sample_ready = advance;

  assign s1 = zref(ch1_sample, internal_cm_reference);
  assign s2 = zref(ch2_sample, internal_cm_reference);
  assign s3 = zref(ch3_sample, internal_cm_reference);

  // Lead arithmetic on the zero-referenced samples
  assign digital_lead  = is_digital_lead(mode);
  assign rate_ok       = rate_allows_digital(data_rate_sel);
  assign lead_i        = s1 - s3;
  assign lead_ii       = s2 - s3;
  assign lead_iii      = s2 - s1;
  assign lead_ii_fixed = {DW{1'b0}} - s2;
  assign limb_sum      = s1 + s2;
  assign ct_third      = div3(limb_sum);
  assign chest_vs_ct   = s3 - ct_third;

  // Channel meaning per mode: analog lead gives leads I, -II, III;
  // single-ended and CE modes give LA, LL, RA/chest against their reference
  always @* begin
    w1_next  = {DW{1'b0}};
    w2_next  = {DW{1'b0}};
    w3_next  = {DW{1'b0}};
    bad_next = !mode_defined(mode);
    case (mode)
      `ELFS_MODE_ANALOG_LEAD: begin
        w1_next = s1;
        w2_next = lead_ii_fixed;
        w3_next = s3;
      end
      `ELFS_MODE_DIGITAL_LEAD: begin
        w1_next  = lead_i;
        w2_next  = lead_ii;
        w3_next  = lead_iii;
        bad_next = !rate_ok;
      end
      `ELFS_MODE_CE_A: begin
        w1_next = s1;
        w2_next = s2;
        w3_next = chest_vs_ct;
      end
      `ELFS_MODE_SE_ELECTRODE: begin
        w1_next = s1;
        w2_next = s2;
        w3_next = s3;
      end
      `ELFS_MODE_CE_B: begin
        w1_next = s1;
        w2_next = s2;
        w3_next = s3;
      end
      default: begin
        w1_next = {DW{1'b0}};
        w2_next = {DW{1'b0}};
        w3_next = {DW{1'b0}};
      end
    endcase
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stage_valid_reg   <= 1'b0;
      w1_reg            <= {DW{1'b0}};
      w2_reg            <= {DW{1'b0}};
      w3_reg            <= {DW{1'b0}};
      mode_unsupported  <= 1'b0;
      cm_select_applied <= 6'h00;
    end else begin
      mode_unsupported  <= bad_next;
      // Common-mode selection is forced off in digital lead mode
      cm_select_applied <= digital_lead ? 6'h00 : common_mode_ref_sel;
      if (advance) begin
        stage_valid_reg <= sample_valid;
        if (sample_valid) begin
          w1_reg <= w1_next;
          w2_reg <= w2_next;
          w3_reg <= w3_next;
        end
      end
    end
  end

  // Stage plus FIFO hold up to ten frames before sample_ready drops
  elfs_fifo #(
    .WIDTH (3*DW),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_fifo (
    .clk       (clk_sys),
    .rst_n     (rst_n),
    .in_valid  (stage_valid_reg),
    .in_ready  (fifo_in_ready),
    .in_data   ({w3_reg, w2_reg, w1_reg}),
    .out_valid (frame_valid),
    .out_ready (frame_ready),
    .out_data  (fifo_out)
  );

  assign word1 = fifo_out[DW-1:0];
  assign word2 = fifo_out[2*DW-1:DW];
  assign word3 = fifo_out[3*DW-1:2*DW];
endmodule
`default_nettype wire

// ### verif/elfs_lead_select_asserts.sv
// Purpose: Port checks for elfs_lead_select
// Assumes: Bound to the top module, one clock domain
// Notes:   Four of the eight checks wait three edges after reset release
`timescale 1ns/1ns
`default_nettype none
module elfs_chk #(parameter DW = 24) (
  input wire logic          clk_sys,
  input wire logic          arst_n,
  input wire logic          frame_data_format,
  input wire logic          input_topology_sel,
  input wire logic          common_electrode_enable,
  input wire logic [1:0]    data_rate_sel,
  input wire logic [5:0]    common_mode_ref_sel,
  input wire logic          sample_valid,
  input wire logic          sample_ready,
  input wire logic [5:0]    cm_select_applied,
  input wire logic          mode_unsupported,
  input wire logic          frame_valid,
  input wire logic          frame_ready,
  input wire logic [DW-1:0] word1,
  input wire logic [DW-1:0] word2,
  input wire logic [DW-1:0] word3
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  wire [2:0] md = {frame_data_format, input_topology_sel, common_electrode_enable};
  wire       bad = (md == 3'h3) || (md[2] && md[1]) || (md == 3'h0 && data_rate_sel[1]);
  // Reset has been seen at one edge at least, so the outputs have settled
  logic      rst_seen = 1'b0;
  always @(posedge clk_sys) if (!arst_n) rst_seen <= 1'b1;
  property p_unsup; $past(arst_n, 3) |-> mode_unsupported == $past(bad); endproperty
  a_unsup: assert property (p_unsup) else $error("mode flag wrong");
  property p_cmsel; $past(arst_n, 3) |->
    cm_select_applied == ($past(md) == 3'h0 ? 6'h00 : $past(common_mode_ref_sel)); endproperty
  a_cmsel: assert property (p_cmsel) else $error("cm select wrong");
  property p_hold; frame_valid && !frame_ready |=> frame_valid && $stable({word1, word2, word3});
  endproperty
  a_hold: assert property (p_hold) else $error("frame not held");
  property p_full; !sample_ready |-> frame_valid; endproperty
  a_full: assert property (p_full) else $error("refused while not full");
  property p_empty; $past(arst_n, 3) && !frame_valid |-> sample_ready; endproperty
  a_empty: assert property (p_empty) else $error("refused while empty");
  property p_lat; sample_valid && sample_ready && !frame_valid |-> ##[1:3] frame_valid; endproperty
  a_lat: assert property (p_lat) else $error("frame late");
  property p_rise; $past(arst_n, 3) && $rose(frame_valid) |-> $past(sample_valid && sample_ready, 3);
  endproperty
  a_rise: assert property (p_rise) else $error("frame without sample");
  property p_rst; disable iff (1'b0)
    rst_seen && !arst_n |-> !frame_valid && !mode_unsupported; endproperty
  a_rst: assert property (p_rst) else $error("outputs live in reset");
  c_unsup: cover property (mode_unsupported);
  c_stall: cover property (!sample_ready);
  c_pop: cover property (frame_valid && frame_ready);
endmodule
bind elfs_lead_select elfs_chk #(
  .DW (DW)
) i_chk (
  .clk_sys                 (clk_sys),
  .arst_n                  (arst_n),
  .frame_data_format       (frame_data_format),
  .input_topology_sel      (input_topology_sel),
  .common_electrode_enable (common_electrode_enable),
  .data_rate_sel           (data_rate_sel),
  .common_mode_ref_sel     (common_mode_ref_sel),
  .sample_valid            (sample_valid),
  .sample_ready            (sample_ready),
  .cm_select_applied       (cm_select_applied),
  .mode_unsupported        (mode_unsupported),
  .frame_valid             (frame_valid),
  .frame_ready             (frame_ready),
  .word1                   (word1),
  .word2                   (word2),
  .word3                   (word3)
);
`default_nettype wire

// ### verif/elfs_sink.sv
// Purpose: Host side frame reader
// Assumes: stall from the bench holds frames back
// Notes:   Accepted frames queue up for the bench
`timescale 1ns/1ns
`default_nettype none
module elfs_sink #(parameter DW = 24) (
  input  wire logic          clk_sys,
  input  wire logic          stall,
  input  wire logic          frame_valid,
  output var  logic          frame_ready,
  input  wire logic [DW-1:0] word1,
  input  wire logic [DW-1:0] word2,
  input  wire logic [DW-1:0] word3
);
  logic [3*DW-1:0] q[$];
  initial frame_ready = 1'b0;
  always @(negedge clk_sys) frame_ready <= !stall;
  // Frames kept whole; the host derives standard leads itself
  always @(posedge clk_sys) if (frame_valid && frame_ready) q.push_back({word1, word2, word3});
endmodule
`default_nettype wire

// ### verif/testbench.sv
// Purpose: Self-checking bench for elfs_lead_select
// Assumes: Inputs change on the falling edge
// Notes:   Expected words follow the per-mode formulas
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic clk_sys = 0, arst_n = 0, stall = 0, sample_valid = 0;
  logic frame_data_format = 0, input_topology_sel = 0, common_electrode_enable = 0;
  logic [1:0] data_rate_sel = 2'h1;
  logic [5:0] common_mode_ref_sel = 6'h2a;
  logic [23:0] internal_cm_reference = 24'h000100, ch1_sample = 0, ch2_sample = 0, ch3_sample = 0;
  wire sample_ready, frame_valid, frame_ready, mode_unsupported;
  wire [5:0] cm_select_applied;
  wire [23:0] word1, word2, word3;
  int error_cnt = 0, checked = 0;
  elfs_lead_select i_dut (.*);
  elfs_sink i_sink (.*);
  initial forever #25 clk_sys = ~clk_sys;
  task automatic complete_run();
    $display("Checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [71:0] got, exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [71:0] expw(input logic [2:0] m, input logic [23:0] a, b, c);
    int x, y, z;
    x = $signed(a - internal_cm_reference);
    y = $signed(b - internal_cm_reference);
    z = $signed(c - internal_cm_reference);
    case (m)
      3'h2: return {24'(x), 24'(-y), 24'(z)};
      3'h0: return {24'(x - z), 24'(y - z), 24'(y - x)};
      3'h1: return {24'(x), 24'(y), 24'(z - (x + y) / 3)};
      3'h4, 3'h5: return {24'(x), 24'(y), 24'(z)};
      default: return 72'h0;
    endcase
  endfunction
  task automatic send(input logic [23:0] a, b, c, output bit ok);
    int n;
    n = 0;
    @(negedge clk_sys);
    {sample_valid, ch1_sample, ch2_sample, ch3_sample} = {1'b1, a, b, c};
    while (!sample_ready && n < 20) begin
      @(negedge clk_sys);
      n++;
    end
    ok = sample_ready;
    @(negedge clk_sys);
    sample_valid = 0;
  endtask
  task automatic pull(output logic [71:0] f);
    int n;
    n = 0;
    while (i_sink.q.size() == 0 && n < 50) begin
      @(negedge clk_sys);
      n++;
    end
    if (n < 50)
      f = i_sink.q.pop_front();
    else begin
      error_cnt++;
      $display("Error %0t: no frame", $time);
      complete_run();
    end
  endtask
  task automatic t_modes();
    bit ok;
    logic [71:0] f;
    for (int m = 0; m < 8; m++) begin
      @(negedge clk_sys);
      {frame_data_format, input_topology_sel, common_electrode_enable} = 3'(m);
      send(24'h012345, 24'hfe0010, 24'h000777, ok);
      chk(ok, 1);
      pull(f);
      chk(f, expw(3'(m), 24'h012345, 24'hfe0010, 24'h000777));
      chk({mode_unsupported, cm_select_applied},
          {m == 3 || m > 5, m == 0 ? 6'h00 : common_mode_ref_sel});
    end
  endtask
  task automatic t_rate();
    {frame_data_format, input_topology_sel, common_electrode_enable} = 3'h0;
    for (int i = 0; i < 4; i++) begin
      data_rate_sel = 2'(i);
      repeat (2) @(negedge clk_sys);
      chk(mode_unsupported, i > 1);
    end
    data_rate_sel = 2'h2;
    input_topology_sel = 1;
    repeat (2) @(negedge clk_sys);
    chk(mode_unsupported, 0);
    data_rate_sel = 2'h1;
  endtask
  task automatic t_fill();
    bit ok;
    int k;
    logic [71:0] f;
    {k, ok, stall} = {32'd0, 2'b11};
    {frame_data_format, input_topology_sel, common_electrode_enable} = 3'h4;
    while (ok && k < 16) begin
      send(24'(k), 24'(k), 24'(k), ok);
      k += ok;
    end
    chk(k, 10);
    stall = 0;
    for (int i = 0; i < 10; i++) begin
      pull(f);
      chk(f, expw(3'h4, 24'(i), 24'(i), 24'(i)));
    end
    @(negedge clk_sys);
    chk(frame_valid, 0);
  endtask
  initial begin
    repeat (10) @(negedge clk_sys);
    arst_n = 1;
    repeat (3) @(negedge clk_sys);
    t_modes();
    t_rate();
    t_fill();
    complete_run();
  end
endmodule
`default_nettype wire
